// ### src/tbsr_link_ready.sv
`timescale 1ns/10ps
module tbsr_link_ready #(
   parameter int unsigned LINKS = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             ce_in,
   input  wire logic             level1_reset_cmd_in,
   input  wire logic [LINKS-1:0] link_receiver_enable_in,
   input  wire logic [LINKS-1:0] align_empty_in,
   input  wire logic [LINKS-1:0] align_full_in,
   output logic                  chip_ready_out
);
   import tbsr_pkg::*;

   tbsr_link_state_e state;
   tbsr_link_state_e next_state;
   logic             next_chip_ready;
   logic [LINKS-1:0] link_ok;
   logic             all_ok;

   genvar i;
   generate
      for (i = 0; i < LINKS; i++)
      begin : g_link
         // Disabled receivers neither help nor block
         assign link_ok[i] = ~link_receiver_enable_in[i] |
                             (~align_empty_in[i] & ~align_full_in[i]);
      end
   endgenerate

   // A chip with every link disabled cannot leave resync for ready
   assign all_ok = (&link_ok) & (|link_receiver_enable_in);

   always_comb
   begin
      next_state = state;
      case (state)
         TBSR_LS_IDLE:
         begin
            if (level1_reset_cmd_in)
               next_state = TBSR_LS_RESYNC;
         end
         TBSR_LS_RESYNC:
         begin
            if (!level1_reset_cmd_in && all_ok)
               next_state = TBSR_LS_READY;
         end
         TBSR_LS_READY:
         begin
            if (level1_reset_cmd_in)
               next_state = TBSR_LS_RESYNC;
         end
         default:
            next_state = TBSR_LS_IDLE;
      endcase
      next_chip_ready = (next_state == TBSR_LS_READY);
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state          <= TBSR_LS_IDLE;
         chip_ready_out <= 1'b0;
      end
      else if (ce_in)
      begin
         state          <= next_state;
         chip_ready_out <= next_chip_ready;
      end
   end

   property p_resync_drops_ready;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && level1_reset_cmd_in) |=> !chip_ready_out;
   endproperty
   a_resync_drops_ready: assert property (p_resync_drops_ready)
      else $error("ready survived a level-1 reset command");

   property p_ready_needs_links;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !chip_ready_out && !all_ok) |=> !chip_ready_out;
   endproperty
   a_ready_needs_links: assert property (p_ready_needs_links)
      else $error("ready raised with an enabled link misaligned");

endmodule

// ### src/tbsr_pkg.sv
package tbsr_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;

   // Register indices on the status port
   localparam logic [3:0] OFS_PIPE_STATUS = 4'h0;
   localparam logic [3:0] OFS_LOOP_CTRL   = 4'h1;
   localparam logic [3:0] OFS_RING_RD     = 4'h2;
   localparam logic [3:0] OFS_RING_WR     = 4'h3;
   localparam logic [3:0] OFS_READY       = 4'h4;
   localparam logic [3:0] OFS_RELEASE     = 4'h5;
   localparam logic [3:0] OFS_SPY_STATUS  = 4'h6;
   localparam logic [3:0] OFS_STN1_SPY    = 4'h7;
   localparam logic [3:0] OFS_STN2_SPY    = 4'h8;
   localparam logic [3:0] OFS_STN3_SPY    = 4'h9;
   localparam logic [3:0] OFS_STN4_SPY    = 4'hA;
   localparam logic [3:0] OFS_PIPE_DELAY  = 4'hB;

   // Field positions
   localparam int unsigned FULL_BIT        = 15;
   localparam int unsigned EMPTY_BIT       = 14;
   localparam int unsigned RX_DATA_VALID_BIT        = 13;
   localparam int unsigned RX_ERROR_BIT        = 12;
   localparam int unsigned LOOP_MODE_LSB   = 4;
   localparam int unsigned TIMING_RDY_BIT  = 0;
   localparam int unsigned BP_LOCK_BIT     = 1;
   localparam int unsigned DB_LOCK_BIT     = 2;
   localparam int unsigned BP_UNLOCK_LSB   = 8;
   localparam int unsigned DB_UNLOCK_LSB   = 12;
   localparam int unsigned MASK_LSB        = 8;
   localparam int unsigned REL_YEAR_LSB    = 12;
   localparam int unsigned REL_MONTH_LSB   = 8;
   localparam int unsigned REL_MARK_LSB    = 5;

   // Values after reset and fixed counts
   localparam logic [1:0]  LOOP_MODE_RST   = 2'h1;
   localparam logic [7:0]  READY_MASK_RST  = 8'hFF;
   localparam logic [7:0]  PIPE_DELAY_RST  = 8'h00;
   localparam logic [9:0]  PIPE_MAX_WORDS  = 10'h200;
   localparam logic [10:0] SPY_MAX_WORDS   = 11'h400;
   localparam logic [3:0]  UNLOCK_MAX      = 4'hF;
   localparam logic [2:0]  REL_MARK        = 3'h7;

   typedef enum logic [1:0] {
      TBSR_LOOP_CAL_RESET  = 2'h0,
      TBSR_LOOP_CAL_LOCK   = 2'h1,
      TBSR_LOOP_STANDALONE = 2'h2
   } tbsr_loop_mode_e;

   typedef enum logic [1:0] {
      TBSR_LS_IDLE   = 2'b00,
      TBSR_LS_RESYNC = 2'b01,
      TBSR_LS_READY  = 2'b11
   } tbsr_link_state_e;

endpackage

// ### src/tbsr_status_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - Pipeline occupancy reads (delay setting plus one) times two once primed, zero before.
// - Pipeline status: 10-bit count, full bit 15 at 512, empty bit 14.
// - Pipeline contents are never readable here; use a spy FIFO instead.
// - Loop mode in bits 5:4: 2 standalone, 1 default, 0 reset-only.
// - Loop register bits 0..2 show timing ready and both lock states.
// - Two 4-bit counters count lock falling edges, saturating at 15.
// - Clock manager reset clears both loss-of-lock counters, to 1 where a falling edge coincides.
// - Read-only register returns the 11-bit ring buffer read pointer.
// - Read-only register returns write pointer in 10:0, upper bits zero.
// - Ready out is masked OR of chips 1..7, ANDed with internal, mask0.
// - Internal ready is high exactly while accept forwarding is enabled.
// - Front chip ready rises once resync after level-1 reset succeeds.
// - Only links with enabled receivers count toward chip readiness.
// - Ready register: mask 15:8 read-write, status 7:0 read-only.
// - Release date register holds year minus 2000, month and day codes.
// - Spy status: 11-bit count, full bit 15 at 1024, empty bit 14.
// - Spy bits 13:12 show receiver status of last word read out.
// - Station spy FIFOs use same count and flag layout as common one.
// - Pipeline delay 0..255 delays data one crossing more than set.
module tbsr_status_regs #(
   parameter int unsigned LINKS      = 4,
   // Arbitrary release date codes
   parameter logic [3:0]  YEAR_CODE  = 4'h0,
   parameter logic [3:0]  MONTH_CODE = 4'h1,
   parameter logic [4:0]  DAY_CODE   = 5'h01
) (
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   input  wire logic                          ce_in,
   input  wire logic [tbsr_pkg::ADDR_W-1:0]   reg_addr_in,
   input  wire logic                          reg_rd_in,
   input  wire logic                          reg_wr_in,
   input  wire logic [tbsr_pkg::DATA_W-1:0]   reg_wdata_in,
   output logic      [tbsr_pkg::DATA_W-1:0]   reg_rdata_out,
   output logic                               reg_ack_out,
   input  wire logic                          pipe_primed_in,
   input  wire logic                          timing_rx_ready_in,
   input  wire logic                          backplane_loop_locked_in,
   input  wire logic                          daughter_loop_locked_in,
   input  wire logic                          clock_mgr_reset_in,
   input  wire logic [10:0]                   ring_rd_ptr_in,
   input  wire logic [10:0]                   ring_wr_ptr_in,
   input  wire logic [7:1]                    chip_ready_in,
   input  wire logic                          accept_forward_en_in,
   input  wire logic                          level1_reset_cmd_in,
   input  wire logic [LINKS-1:0]              link_receiver_enable_in,
   input  wire logic [LINKS-1:0]              align_empty_in,
   input  wire logic [LINKS-1:0]              align_full_in,
   input  wire logic [10:0]                   spy_word_count_in,
   input  wire logic                          spy_pop_in,
   input  wire logic                          rx_data_valid_in,
   input  wire logic                          rx_error_in,
   input  wire logic [10:0]                   station1_spy_count_in,
   input  wire logic [10:0]                   station2_spy_count_in,
   input  wire logic [10:0]                   station3_spy_count_in,
   input  wire logic [10:0]                   station4_spy_count_in,
   output logic      [1:0]                    loop_mode_out,
   output logic      [7:0]                    pipe_delay_out,
   output logic                               ready_out,
   output logic                               front_ready_out
);
   import tbsr_pkg::*;

   logic [3:0]  daughter_unlock_count;
   logic [3:0]  backplane_unlock_count;
   logic        bp_lock_prev;
   logic        db_lock_prev;
   logic [7:0]  ready_chip_mask;
   logic        spy_rx_dv;
   logic        spy_rx_er;

   logic [1:0]  next_loop_mode;
   logic [7:0]  next_pipe_delay;
   logic [7:0]  next_ready_chip_mask;
   logic [3:0]  next_daughter_unlock_count;
   logic [3:0]  next_backplane_unlock_count;
   logic        next_spy_rx_dv;
   logic        next_spy_rx_er;
   logic        next_ready;
   logic [15:0] next_rdata;
   logic        next_ack;

   logic        internal_ready;
   logic        bp_fall;
   logic        db_fall;
   logic [9:0]  pipe_word_count;
   logic [7:0]  ready_status;
   logic        wr_loop;
   logic        wr_ready;
   logic        wr_delay;

   // Shared layout of every spy FIFO status word
   function automatic logic [15:0] spy_word(input logic [10:0] count,
                                            input logic        dv,
                                            input logic        er);
      logic [15:0] w;
      w            = 16'h0000;
      w[10:0]      = count;
      w[FULL_BIT]  = (count == SPY_MAX_WORDS);
      w[EMPTY_BIT] = (count == 11'h000);
      w[RX_DATA_VALID_BIT]  = dv;
      w[RX_ERROR_BIT]  = er;
      return w;
   endfunction

   // Counter saturates at 15; a clear that meets an edge keeps the edge
   function automatic logic [3:0] unlock_next(input logic [3:0] count,
                                              input logic       fall,
                                              input logic       clear);
      logic [3:0] n;
      n = count;
      if (clear)
         n = fall ? 4'h1 : 4'h0;
      else if (fall && (count != UNLOCK_MAX))
         n = count + 4'h1;
      return n;
   endfunction

   tbsr_link_ready #(
      .LINKS (LINKS)
   ) u_link_ready (
      .clk_in                  (clk_in),
      .rst_in                  (rst_in),
      .ce_in                   (ce_in),
      .level1_reset_cmd_in     (level1_reset_cmd_in),
      .link_receiver_enable_in (link_receiver_enable_in),
      .align_empty_in          (align_empty_in),
      .align_full_in           (align_full_in),
      .chip_ready_out          (front_ready_out)
   );

   assign internal_ready = accept_forward_en_in;
   assign bp_fall  = bp_lock_prev & ~backplane_loop_locked_in;
   assign db_fall  = db_lock_prev & ~daughter_loop_locked_in;
   // Doubled crossing rate: (delay + 1) * 2, 512 at the top setting
   assign pipe_word_count = pipe_primed_in ?
                            {1'b0, pipe_delay_out} + 10'h001 << 1 : 10'h000;
   assign ready_status = {chip_ready_in, ready_out};
   assign wr_loop  = reg_wr_in && (reg_addr_in == OFS_LOOP_CTRL);
   assign wr_ready = reg_wr_in && (reg_addr_in == OFS_READY);
   assign wr_delay = reg_wr_in && (reg_addr_in == OFS_PIPE_DELAY);

   always_comb
   begin
      next_loop_mode       = loop_mode_out;
      next_pipe_delay      = pipe_delay_out;
      next_ready_chip_mask = ready_chip_mask;
      if (wr_loop)
         next_loop_mode = reg_wdata_in[LOOP_MODE_LSB +: 2];
      if (wr_delay)
         next_pipe_delay = reg_wdata_in[7:0];
      // Status half of the write is dropped
      if (wr_ready)
         next_ready_chip_mask = reg_wdata_in[MASK_LSB +: 8];

      next_daughter_unlock_count  = unlock_next(daughter_unlock_count, db_fall,
                                                clock_mgr_reset_in);
      next_backplane_unlock_count = unlock_next(backplane_unlock_count, bp_fall,
                                                clock_mgr_reset_in);

      // Receiver status follows the word the host just drained
      next_spy_rx_dv = spy_rx_dv;
      next_spy_rx_er = spy_rx_er;
      if (spy_pop_in)
      begin
         next_spy_rx_dv = rx_data_valid_in;
         next_spy_rx_er = rx_error_in;
      end

      next_ready = (|(chip_ready_in & ready_chip_mask[7:1])) &
                   internal_ready & ready_chip_mask[0];
   end

   // Read mux; reads only select, so nothing reported changes on a read
   always_comb
   begin
      next_ack   = reg_rd_in | reg_wr_in;
      next_rdata = 16'h0000;
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            // Occupancy and flags only; no data path out of the pipeline
            OFS_PIPE_STATUS:
            begin
               next_rdata[9:0]       = pipe_word_count;
               next_rdata[FULL_BIT]  = (pipe_word_count == PIPE_MAX_WORDS);
               next_rdata[EMPTY_BIT] = (pipe_word_count == 10'h000);
            end
            OFS_LOOP_CTRL:
            begin
               next_rdata[TIMING_RDY_BIT]         = timing_rx_ready_in;
               next_rdata[BP_LOCK_BIT]            = backplane_loop_locked_in;
               next_rdata[DB_LOCK_BIT]            = daughter_loop_locked_in;
               next_rdata[LOOP_MODE_LSB +: 2]     = loop_mode_out;
               next_rdata[BP_UNLOCK_LSB +: 4]     = backplane_unlock_count;
               next_rdata[DB_UNLOCK_LSB +: 4]     = daughter_unlock_count;
            end
            OFS_RING_RD:
               next_rdata[10:0] = ring_rd_ptr_in;
            OFS_RING_WR:
               next_rdata[10:0] = ring_wr_ptr_in;
            OFS_READY:
               next_rdata = {ready_chip_mask, ready_status};
            OFS_RELEASE:
            begin
               next_rdata[REL_YEAR_LSB +: 4]  = YEAR_CODE;
               next_rdata[REL_MONTH_LSB +: 4] = MONTH_CODE;
               next_rdata[REL_MARK_LSB +: 3]  = REL_MARK;
               next_rdata[4:0]                = DAY_CODE;
            end
            OFS_SPY_STATUS:
               next_rdata = spy_word(spy_word_count_in, spy_rx_dv, spy_rx_er);
            OFS_STN1_SPY:
               next_rdata = spy_word(station1_spy_count_in, 1'b0, 1'b0);
            OFS_STN2_SPY:
               next_rdata = spy_word(station2_spy_count_in, 1'b0, 1'b0);
            OFS_STN3_SPY:
               next_rdata = spy_word(station3_spy_count_in, 1'b0, 1'b0);
            OFS_STN4_SPY:
               next_rdata = spy_word(station4_spy_count_in, 1'b0, 1'b0);
            OFS_PIPE_DELAY:
               next_rdata[7:0] = pipe_delay_out;
            default:
               next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         loop_mode_out          <= LOOP_MODE_RST;
         pipe_delay_out         <= PIPE_DELAY_RST;
         ready_chip_mask        <= READY_MASK_RST;
         daughter_unlock_count  <= 4'h0;
         backplane_unlock_count <= 4'h0;
         bp_lock_prev           <= 1'b0;
         db_lock_prev           <= 1'b0;
         spy_rx_dv              <= 1'b0;
         spy_rx_er              <= 1'b0;
         ready_out              <= 1'b0;
         reg_rdata_out          <= 16'h0000;
         reg_ack_out            <= 1'b0;
      end
      else if (ce_in)
      begin
         loop_mode_out          <= next_loop_mode;
         pipe_delay_out         <= next_pipe_delay;
         ready_chip_mask        <= next_ready_chip_mask;
         daughter_unlock_count  <= next_daughter_unlock_count;
         backplane_unlock_count <= next_backplane_unlock_count;
         bp_lock_prev           <= backplane_loop_locked_in;
         db_lock_prev           <= daughter_loop_locked_in;
         spy_rx_dv              <= next_spy_rx_dv;
         spy_rx_er              <= next_spy_rx_er;
         ready_out              <= next_ready;
         reg_rdata_out          <= next_rdata;
         reg_ack_out            <= next_ack;
      end
   end

   property p_pipe_words;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && reg_rd_in && reg_addr_in == OFS_PIPE_STATUS && pipe_primed_in)
      |=> reg_rdata_out[9:0] == ({2'b00, $past(pipe_delay_out)} + 10'h001) * 10'h002;
   endproperty
   a_pipe_words: assert property (p_pipe_words)
      else $error("pipeline occupancy not twice delay plus one");

   property p_pipe_full;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && reg_rd_in && reg_addr_in == OFS_PIPE_STATUS)
      |=> reg_rdata_out[FULL_BIT] == (reg_rdata_out[9:0] == PIPE_MAX_WORDS)
          && reg_rdata_out[13:10] == 4'h0;
   endproperty
   a_pipe_full: assert property (p_pipe_full)
      else $error("pipeline full flag disagrees with count");

   property p_loop_mode_write;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && wr_loop) |=> loop_mode_out == $past(reg_wdata_in[5:4]);
   endproperty
   a_loop_mode_write: assert property (p_loop_mode_write)
      else $error("loop mode field did not take the write");

   property p_loop_status;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && reg_rd_in && reg_addr_in == OFS_LOOP_CTRL)
      |=> reg_rdata_out[2:0] == $past({daughter_loop_locked_in,
                                      backplane_loop_locked_in, timing_rx_ready_in});
   endproperty
   a_loop_status: assert property (p_loop_status)
      else $error("loop status bits wrong");

   property p_unlock_count;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !clock_mgr_reset_in && bp_fall && backplane_unlock_count != UNLOCK_MAX)
      |=> backplane_unlock_count == $past(backplane_unlock_count) + 4'h1;
   endproperty
   a_unlock_count: assert property (p_unlock_count)
      else $error("backplane unlock edge not counted");

   property p_unlock_sat;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && !clock_mgr_reset_in && daughter_unlock_count == UNLOCK_MAX)
      |=> daughter_unlock_count == UNLOCK_MAX;
   endproperty
   a_unlock_sat: assert property (p_unlock_sat)
      else $error("daughter unlock counter left saturation");

   property p_unlock_clear;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && clock_mgr_reset_in && !db_fall) |=> daughter_unlock_count == 4'h0;
   endproperty
   a_unlock_clear: assert property (p_unlock_clear)
      else $error("clock manager reset did not clear history");

   property p_ring_wr;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && reg_rd_in && reg_addr_in == OFS_RING_WR)
      |=> reg_rdata_out == {5'h00, $past(ring_wr_ptr_in)};
   endproperty
   a_ring_wr: assert property (p_ring_wr)
      else $error("ring write pointer read wrong");

   property p_ready_combine;
      @(posedge clk_in) disable iff (rst_in)
      ce_in |=> ready_out == ($past(|(chip_ready_in & ready_chip_mask[7:1]))
                              && $past(accept_forward_en_in) && $past(ready_chip_mask[0]));
   endproperty
   a_ready_combine: assert property (p_ready_combine)
      else $error("ready output not the masked combination");

   property p_ready_wr;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && wr_ready) ##1 (ce_in && reg_rd_in && reg_addr_in == OFS_READY)
      |=> reg_rdata_out[15:8] == $past(reg_wdata_in[15:8], 2)
          && reg_rdata_out[7:1] == $past(chip_ready_in);
   endproperty
   a_ready_wr: assert property (p_ready_wr)
      else $error("ready register mask or status wrong");

   property p_spy_capture;
      @(posedge clk_in) disable iff (rst_in)
      (ce_in && spy_pop_in) |=> {spy_rx_dv, spy_rx_er} ==
                                $past({rx_data_valid_in, rx_error_in});
   endproperty
   a_spy_capture: assert property (p_spy_capture)
      else $error("spy receiver status not captured on pop");

endmodule

// ### tb/tbsr_status_regs_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tbsr_status_regs_test;
   import tbsr_pkg::*;
   logic        clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, reg_rd_in = 1'b0, reg_wr_in = 1'b0;
   logic [3:0]  reg_addr_in = 4'h0, len = 4'h0, aem = 4'hF, afu = 4'h0;
   logic [15:0] reg_wdata_in = 16'h0, reg_rdata_out, e16;
   logic        reg_ack_out, ready_out, front_ready_out, rdy;
   logic        primed = 1'b0, trdy = 1'b1, bpl = 1'b1, dbl = 1'b1, cmr = 1'b0, afe = 1'b0;
   logic        l1r = 1'b0, pop = 1'b0, dv = 1'b0, er = 1'b0;
   logic [10:0] rp = 11'h0, wp = 11'h0, sc = 11'h0, ss = 11'h0, v;
   logic [7:1]  chip = 7'h0, c;
   logic [1:0]  loop_mode_out;
   logic [7:0]  pipe_delay_out, m, dl;
   logic [9:0]  cnt;
   logic [31:0] lf = 32'h3977;
   logic [15:0] q[$];
   int          n_errors = 0, n_compared = 0;

   always #5 clk_in = ~clk_in;

   tbsr_status_regs i_dut (.clk_in, .rst_in, .ce_in, .reg_addr_in, .reg_rd_in, .reg_wr_in,
      .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .pipe_primed_in(primed),
      .timing_rx_ready_in(trdy), .backplane_loop_locked_in(bpl), .daughter_loop_locked_in(dbl),
      .clock_mgr_reset_in(cmr), .ring_rd_ptr_in(rp), .ring_wr_ptr_in(wp), .chip_ready_in(chip),
      .accept_forward_en_in(afe), .level1_reset_cmd_in(l1r), .link_receiver_enable_in(len),
      .align_empty_in(aem), .align_full_in(afu), .spy_word_count_in(sc), .spy_pop_in(pop),
      .rx_data_valid_in(dv), .rx_error_in(er), .station1_spy_count_in(ss),
      .station2_spy_count_in(ss), .station3_spy_count_in(ss), .station4_spy_count_in(ss),
      .loop_mode_out, .pipe_delay_out, .ready_out, .front_ready_out);

   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Gap of a few cycles lets status inputs settle before the sample
   task automatic acc(input logic [3:0] a, input logic w, input logic [15:0] d,
                      input logic [15:0] e);
      repeat (3) @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= !w;
      reg_wr_in <= w;
      reg_wdata_in <= d;
      q.push_back(w ? 16'h0 : e);
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      reg_wr_in <= 1'b0;
   endtask

   task automatic summarize;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk_in)
      if (reg_ack_out === 1'b1)
      begin
         e16 = q.pop_front();
         `CHK("rdata", e16, reg_rdata_out)
      end

   initial
   begin
      #100000;
      n_errors++;
      summarize();
   end

   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      acc(OFS_LOOP_CTRL, 1'b0, 16'h0, 16'h0017);
      `CHK("front", 1'b0, front_ready_out)
      acc(OFS_READY, 1'b0, 16'h0, 16'hFF00);
      acc(OFS_PIPE_STATUS, 1'b0, 16'h0, 16'h4000);
      acc(OFS_RELEASE, 1'b0, 16'h0, 16'h01E1);
      acc(4'hC, 1'b0, 16'h0, 16'h0);
      primed <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         lf = nx(lf);
         dl = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lf[7:0];
         cnt = ({2'b00, dl} + 10'h1) * 10'h2;
         acc(OFS_PIPE_DELAY, 1'b1, {8'hA5, dl}, 16'h0);
         acc(OFS_PIPE_DELAY, 1'b0, 16'h0, {8'h00, dl});
         acc(OFS_PIPE_STATUS, 1'b0, 16'h0, {cnt == 10'h200, 5'h0, cnt});
         `CHK("delay", dl, pipe_delay_out)
      end
      for (int i = 0; i < 3; i++)
      begin
         acc(OFS_LOOP_CTRL, 1'b1, {10'h0, 2'(i), 4'h0}, 16'h0);
         acc(OFS_LOOP_CTRL, 1'b0, 16'h0, {10'h0, 2'(i), 4'h7});
         `CHK("mode", 2'(i), loop_mode_out)
      end
      for (int j = 0; j < 17; j++)
      begin
         @(posedge clk_in);
         bpl <= 1'b0;
         dbl <= (j >= 2);
         @(posedge clk_in);
         bpl <= 1'b1;
         dbl <= 1'b1;
      end
      acc(OFS_LOOP_CTRL, 1'b0, 16'h0, 16'h2F27);
      cmr <= 1'b1;
      trdy <= 1'b0;
      @(posedge clk_in);
      cmr <= 1'b0;
      acc(OFS_LOOP_CTRL, 1'b0, 16'h0, 16'h0026);
      lf = nx(lf);
      rp <= lf[10:0];
      wp <= lf[21:11];
      acc(OFS_RING_RD, 1'b0, 16'h0, {5'h0, lf[10:0]});
      acc(OFS_RING_WR, 1'b0, 16'h0, {5'h0, lf[21:11]});
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_in);
         lf = nx(lf);
         m = (i == 0) ? 8'hFF : lf[7:0];
         c = lf[15:9] | {6'h0, i == 0};
         chip <= c;
         afe <= lf[16] | (i == 0);
         rdy = (|(c & m[7:1])) & (lf[16] | (i == 0)) & m[0];
         acc(OFS_READY, 1'b1, {m, 8'hFF}, 16'h0);
         acc(OFS_READY, 1'b0, 16'h0, {m, c, rdy});
         @(negedge clk_in);
         `CHK("ready", rdy, ready_out)
      end
      // Back-to-back write then read; status half of the write must be dropped
      @(posedge clk_in);
      reg_addr_in <= OFS_READY;
      reg_wr_in <= 1'b1;
      reg_wdata_in <= {m, 8'h00};
      q.push_back(16'h0);
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b1;
      q.push_back({m, c, rdy});
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         lf = nx(lf);
         v = (k == 0) ? 11'h400 : (k == 1) ? 11'h0 : {1'b0, lf[9:0]};
         sc <= v;
         ss <= v;
         pop <= 1'b1;
         dv <= ~k[0];
         er <= k[0];
         @(posedge clk_in);
         pop <= 1'b0;
         dv <= k[0];
         er <= ~k[0];
         acc(OFS_SPY_STATUS, 1'b0, 16'h0,
             {v == 11'h400, v == 11'h0, ~k[0], k[0], 1'b0, v});
         for (logic [3:0] a = OFS_STN1_SPY; a <= OFS_STN4_SPY; a++)
            acc(a, 1'b0, 16'h0, {v == 11'h400, v == 11'h0, 3'h0, v});
      end
      len <= 4'h3;
      aem <= 4'h5;
      l1r <= 1'b1;
      @(posedge clk_in);
      l1r <= 1'b0;
      repeat (4) @(negedge clk_in);
      `CHK("front", 1'b0, front_ready_out)
      @(posedge clk_in);
      aem <= 4'h4;
      repeat (4) @(negedge clk_in);
      `CHK("front", 1'b1, front_ready_out)
      // Clock enable low must hold ready through a reset command
      @(posedge clk_in);
      ce_in <= 1'b0;
      l1r <= 1'b1;
      repeat (3) @(posedge clk_in);
      ce_in <= 1'b1;
      l1r <= 1'b0;
      @(negedge clk_in);
      `CHK("front", 1'b1, front_ready_out)
      @(posedge clk_in);
      l1r <= 1'b1;
      afu <= 4'h2;
      @(posedge clk_in);
      l1r <= 1'b0;
      repeat (4) @(negedge clk_in);
      `CHK("front", 1'b0, front_ready_out)
      @(posedge clk_in);
      afu <= 4'h8;
      repeat (4) @(negedge clk_in);
      `CHK("front", 1'b1, front_ready_out)
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      `CHK("front", 1'b0, front_ready_out)
      acc(OFS_LOOP_CTRL, 1'b0, 16'h0, 16'h0016);
      acc(OFS_PIPE_DELAY, 1'b0, 16'h0, 16'h0000);
      repeat (3) @(posedge clk_in);
      summarize();
   end
endmodule
